// file: adcirq_top.sv
// adcirq_top: interrupt enable/disable/mask and per-channel result registers
// of an eight-channel converter, with status events and an apb slave.
// assumes conversion results arrive as one-cycle pulses on clk.
`timescale 1ns/10ps
module adcirq_top
    import adcirq_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // apb slave
    input  wire adcirq_apb_req_t   apb_req,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // converter events
    input  wire adcirq_conv_t      conv,
    input  wire logic              general_overrun,
    input  wire adcirq_dma_t       dma,
    // interrupt
    output logic                   irq
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic              setup;
    logic              wr_acc;
    logic              rd_acc;
    logic              ready_q;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              in_results;
    logic [2:0]        res_idx;

    assign addr       = apb_req.paddr;
    assign wdata      = apb_req.pwdata;
    assign setup      = apb_req.psel && !apb_req.penable;
    // effects land on the edge that launches pready, so read data capture
    // the old flags before a read-clear takes them away
    assign wr_acc     = apb_req.psel && apb_req.penable && apb_req.pwrite
                     && !ready_q && !pready;
    assign rd_acc     = apb_req.psel && apb_req.penable && !apb_req.pwrite
                     && !ready_q && !pready;
    assign in_results = addr >= OFF_RESULT_BASE
                     && addr < OFF_RESULT_BASE + ADDR_W'(4 * CH)
                     && addr[1:0] == 2'b00;
    assign res_idx    = 3'((addr - OFF_RESULT_BASE) >> 2);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= setup;
        end
    end

    // ------------------------------------------------------------------
    // channel enable
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] ch_en_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ch_en_q <= RST_CH_EN;
        end else if (wr_acc && hit(addr, OFF_CH_ENABLE)) begin
            ch_en_q <= ch_en_q | wdata[NUM_CH-1:0];
        end else if (wr_acc && hit(addr, OFF_CH_DISABLE)) begin
            ch_en_q <= ch_en_q & ~wdata[NUM_CH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // interrupt mask
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] mask_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_q <= RST_IRQ_MASK;
        end else if (wr_acc && hit(addr, OFF_IRQ_ENABLE)) begin
            mask_q <= mask_q | wdata[IRQ_W-1:0];
        end else if (wr_acc && hit(addr, OFF_IRQ_DISABLE)) begin
            mask_q <= mask_q & ~wdata[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // conversion results
    // ------------------------------------------------------------------
    logic             conv_ok;
    logic [RES_W-1:0] last_q;
    logic [RES_W-1:0] res_rd;

    assign conv_ok = conv.valid && ch_en_q[conv.channel];

    adcirq_result_mem #(
        .DEPTH (NUM_CH),
        .WIDTH (RES_W)
    ) u_mem (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (conv_ok),
        .wr_addr (conv.channel),
        .wr_data (conv.data),
        .rd_addr (res_idx),
        .rd_data (res_rd)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            last_q <= RST_RESULT;
        end else if (conv_ok) begin
            last_q <= conv.data;
        end
    end

    // ------------------------------------------------------------------
    // status events
    // ------------------------------------------------------------------
    logic              rd_status;
    logic              rd_last;
    logic [NUM_CH-1:0] done_q;
    logic [NUM_CH-1:0] ovr_q;
    logic              result_available_flag_q;
    logic              govr_q;
    logic [IRQ_W-1:0]  status;

    assign rd_status = rd_acc && hit(addr, OFF_STATUS);
    assign rd_last   = rd_acc && hit(addr, OFF_LAST_RESULT);

    // done stays while the channel holds unread result; disabling drops it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            done_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!ch_en_q[i]) begin
                    done_q[i] <= 1'b0;
                end else if (conv_ok && conv.channel == 3'(i)) begin
                    done_q[i] <= 1'b1;
                end else if (rd_acc && in_results && res_idx == 3'(i)) begin
                    done_q[i] <= 1'b0;
                end
            end
        end
    end

    // overrun: new result lands while the previous one is still unread
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ovr_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (conv_ok && conv.channel == 3'(i) && done_q[i]) begin
                    ovr_q[i] <= 1'b1;
                end else if (rd_status) begin
                    ovr_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            result_available_flag_q <= 1'b0;
        end else if (conv_ok) begin
            result_available_flag_q <= 1'b1;
        end else if (rd_last) begin
            result_available_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            govr_q <= 1'b0;
        end else if (general_overrun || (conv_ok && result_available_flag_q)) begin
            govr_q <= 1'b1;
        end else if (rd_status) begin
            govr_q <= 1'b0;
        end
    end

    always_comb begin
        status = '0;
        status[BIT_DONE0 +: NUM_CH] = done_q;
        status[BIT_OVR0 +: NUM_CH]  = ovr_q;
        status[BIT_RESULT_AVAILABLE_FLAG]            = result_available_flag_q;
        status[BIT_GOVR]            = govr_q;
        status[BIT_RX_END]          = dma.rx_end;
        status[BIT_RX_FULL]         = dma.rx_full;
    end

    // ------------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // read mux and answer
    // ------------------------------------------------------------------
    logic [31:0] rdata;
    logic        known;

    always_comb begin
        rdata = 32'h0000_0000;
        known = 1'b1;
        if (!apb_req.pwrite && in_results) begin
            rdata = {22'h000000, res_rd};
        end else if (!apb_req.pwrite && hit(addr, OFF_IRQ_MASK)) begin
            rdata = {12'h000, mask_q};
        end else if (!apb_req.pwrite && hit(addr, OFF_STATUS)) begin
            rdata = {12'h000, status};
        end else if (!apb_req.pwrite && hit(addr, OFF_LAST_RESULT)) begin
            rdata = {22'h000000, last_q};
        end else if (!apb_req.pwrite && hit(addr, OFF_CH_STATUS)) begin
            rdata = {24'h000000, ch_en_q};
        end else if (apb_req.pwrite && (hit(addr, OFF_CH_ENABLE)
                  || hit(addr, OFF_CH_DISABLE) || hit(addr, OFF_IRQ_ENABLE)
                  || hit(addr, OFF_IRQ_DISABLE))) begin
            rdata = 32'h0000_0000;
        end else begin
            known = 1'b0;
        end
    end

    // unmapped or wrong-direction access answers with pslverr
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_req.psel && apb_req.penable && !ready_q && !pready;
            prdata  <= (apb_req.psel && !apb_req.pwrite) ? rdata : 32'h0000_0000;
            pslverr <= apb_req.psel && apb_req.penable && !ready_q && !pready && !known;
        end
    end

endmodule

// file: adcirq_pkg.sv
// adcirq_pkg: register map, bit layout and carrier types for the converter
// interrupt and channel result block; assumes a 32-bit apb slave in front.
package adcirq_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH    = 8;
    localparam int RES_W     = 10;
    localparam int IRQ_W     = 20;
    localparam int ADDR_W    = 8;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CH_ENABLE   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CH_DISABLE  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CH_STATUS   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_LAST_RESULT = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE  = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_IRQ_DISABLE = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK    = 8'h2c;
    localparam logic [ADDR_W-1:0] OFF_RESULT_BASE = 8'h30;

    // ------------------------------------------------------------------
    // field positions in status and mask layout
    // ------------------------------------------------------------------
    localparam int BIT_DONE0     = 0;
    localparam int BIT_OVR0      = 8;
    localparam int BIT_RESULT_AVAILABLE_FLAG      = 16;
    localparam int BIT_GOVR      = 17;
    localparam int BIT_RX_END    = 18;
    localparam int BIT_RX_FULL   = 19;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [IRQ_W-1:0]  RST_IRQ_MASK  = 20'h00000;
    localparam logic [NUM_CH-1:0] RST_CH_EN     = 8'h00;
    localparam logic [RES_W-1:0]  RST_RESULT    = 10'h000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic [2:0]        channel;
        logic [RES_W-1:0]  data;
    } adcirq_conv_t;

    typedef struct packed {
        logic              rx_end;
        logic              rx_full;
    } adcirq_dma_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } adcirq_apb_req_t;

endpackage

// file: adcirq_result_mem.sv
// adcirq_result_mem: per-channel result store, one word per channel.
// assumes one write and one read per clock; read data are registered.
`timescale 1ns/10ps
module adcirq_result_mem
    import adcirq_pkg::*;
#(
    parameter int DEPTH = NUM_CH,
    parameter int WIDTH = RES_W
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // write side
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // read side
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= WIDTH'(0);
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // write-through so a read in the loading cycle sees the new result
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data <= WIDTH'(0);
        end else if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule

// file: adcirq_top_assertions.sv
// adcirq_top_assertions: apb timing, refusals and irq checks on top ports.
// assumes only the ports of adcirq_top; bound in at the foot.
`timescale 1ns/10ps
module adcirq_top_assertions
    import adcirq_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    // clock and reset
    input wire logic            clk,
    input wire logic            rstn,
    // apb
    input wire adcirq_apb_req_t apb_req,
    input wire logic            pready,
    input wire logic [31:0]     prdata,
    input wire logic            pslverr,
    // events
    input wire adcirq_conv_t    conv,
    input wire logic            general_overrun,
    input wire adcirq_dma_t     dma,
    input wire logic            irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic rd_end;
    logic wr_end;
    logic strobe;
    logic res;
    assign rd_end = pready && !apb_req.pwrite;
    assign wr_end = pready && apb_req.pwrite;
    assign strobe = apb_req.paddr inside {OFF_IRQ_ENABLE, OFF_IRQ_DISABLE};
    assign res    = apb_req.paddr >= OFF_RESULT_BASE && apb_req.paddr < OFF_RESULT_BASE + 4 * CH;

    a_answer_bound: assert property (apb_req.psel && !apb_req.penable |-> ##[1:3] pready)
        else $error("apb answer late");
    a_ready_access: assert property (pready |-> apb_req.psel && apb_req.penable)
        else $error("pready outside access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_strobe_ok: assert property (wr_end && strobe |-> !pslverr)
        else $error("strobe write refused");
    a_strobe_wo: assert property (rd_end && strobe |-> pslverr)
        else $error("strobe read accepted");
    a_mask_upper: assert property (rd_end && apb_req.paddr == OFF_IRQ_MASK
        |-> prdata[31:20] == 12'h000 && !pslverr)
        else $error("mask upper bits set");
    a_result_upper: assert property (rd_end && res |-> prdata[31:10] == 22'h0 && !pslverr)
        else $error("result upper bits set");
    a_ro_refused: assert property (wr_end && (res || apb_req.paddr == OFF_IRQ_MASK) |-> pslverr)
        else $error("read-only write accepted");
    a_irq_masked: assert property (rd_end && apb_req.paddr == OFF_IRQ_MASK && prdata == 32'h0
        |-> !irq)
        else $error("irq with empty mask");
endmodule

bind adcirq_top adcirq_top_assertions #(.CH(CH)) adcirq_top_assertions_inst (
    .clk(clk), .rstn(rstn), .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .conv(conv), .general_overrun(general_overrun), .dma(dma), .irq(irq));

// file: adcirq_tb_top.sv
// adcirq_tb_top: directed bench for the irq mask and channel result block.
// assumes the checker file is compiled alongside and bound in.
`timescale 1ns/10ps
module adcirq_tb_top;
    import adcirq_pkg::*;

    logic            clk;
    logic            rstn;
    logic            general_overrun;
    logic            pready;
    logic            pslverr;
    logic            irq;
    logic            e;
    logic [31:0]     prdata;
    logic [31:0]     r;
    adcirq_apb_req_t apb_req;
    adcirq_conv_t    conv;
    adcirq_dma_t     dma;
    int              error_cnt;
    int              compares;

    adcirq_top #(.CH(NUM_CH)) adcirq_top_inst (.clk(clk), .rstn(rstn), .apb_req(apb_req),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .conv(conv),
        .general_overrun(general_overrun), .dma(dma), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // idle cycles after release so irq has settled before the caller looks
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        apb_req <= '{a, 1'b1, 1'b0, wr, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            close_out();
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic cv(input logic [2:0] ch, input logic [9:0] d);
        conv <= '{1'b1, ch, d};
        @(posedge clk);
        conv.valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic s_mask();
        apb(1'b0, OFF_IRQ_MASK, 32'h0);
        chk("mask reset", r, 32'h0);
        chk("irq reset", {31'h0, irq}, 32'h0);
        apb(1'b1, OFF_IRQ_ENABLE, 32'hffffffff);
        apb(1'b0, OFF_IRQ_MASK, 32'h0);
        chk("mask all", r, 32'h000fffff);
        apb(1'b1, OFF_IRQ_DISABLE, 32'h00055555);
        apb(1'b1, OFF_IRQ_DISABLE, 32'h0);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
        apb(1'b1, OFF_IRQ_MASK, 32'hffffffff);
        chk("mask write err", {31'h0, e}, 32'h1);
        apb(1'b0, OFF_IRQ_MASK, 32'h0);
        chk("mask part", r, 32'h000aaaaa);
        apb(1'b0, OFF_IRQ_DISABLE, 32'h0);
        chk("strobe read err", {31'h0, e}, 32'h1);
        apb(1'b1, OFF_IRQ_DISABLE, 32'hffffffff);
    endtask

    task automatic s_result();
        apb(1'b1, OFF_CH_ENABLE, 32'h0000000f);
        for (int i = 0; i < NUM_CH; i++) begin
            cv(i[2:0], 10'h3fc | i[9:0]);
        end
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("done flags", {24'h0, r[7:0]}, 32'h0000000f);
        for (int i = 0; i < NUM_CH; i++) begin
            apb(1'b0, OFF_RESULT_BASE + 8'(4 * i), 32'h0);
            chk("result", r, (i < 4) ? 32'h3fc | i : 32'h0);
        end
        apb(1'b1, OFF_RESULT_BASE, 32'h0);
        apb(1'b0, OFF_RESULT_BASE + 8'h0c, 32'h0);
        chk("result held", r, 32'h000003ff);
    endtask

    task automatic s_irq();
        apb(1'b1, OFF_IRQ_ENABLE, 32'h1 << BIT_RESULT_AVAILABLE_FLAG);
        apb(1'b0, OFF_LAST_RESULT, 32'h0);
        chk("irq idle", {31'h0, irq}, 32'h0);
        cv(3'd0, 10'h155);
        chk("irq ready", {31'h0, irq}, 32'h1);
        apb(1'b0, OFF_LAST_RESULT, 32'h0);
        chk("last data", {22'h0, r[9:0]}, 32'h00000155);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        cv(3'd1, 10'h001);
        cv(3'd1, 10'h002);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("overrun set", {31'h0, r[BIT_OVR0 + 1]}, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("overrun clear", {31'h0, r[BIT_OVR0 + 1]}, 32'h0);
        general_overrun <= 1'b1;
        dma <= '{1'b1, 1'b1};
        @(posedge clk);
        general_overrun <= 1'b0;
        repeat (2) @(posedge clk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("upper events", {28'h0, r[19:16]}, 32'h0000000f);
        apb(1'b1, OFF_IRQ_DISABLE, 32'h000fffff);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h1 << BIT_RX_END);
        chk("irq dma", {31'h0, irq}, 32'h1);
        apb(1'b1, OFF_IRQ_DISABLE, 32'h1 << BIT_RX_END);
        apb(1'b0, OFF_IRQ_MASK, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
    endtask

    initial begin
        rstn = 1'b0;
        apb_req = '0;
        conv = '0;
        dma = '0;
        general_overrun = 1'b0;
        error_cnt = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        s_mask();
        s_result();
        s_irq();
        close_out();
    end
endmodule
